// ### hdl/ieu_map.svh
// Constants for the interrupt entry unit: vectors, counts and field positions
`ifndef IEU_MAP_SVH
`define IEU_MAP_SVH

`define IEU_NSRC 8
`define IEU_IDX_W 3
`define IEU_VEC_TRAP 16'hFFFC
`define IEU_VEC_HW_BASE 16'hFFFA
`define IEU_PUSH_LAST 3'h4
`define IEU_PUSH_COUNT 16'h0005
`define IEU_IMASK_BIT 3

`endif

// ### hdl/ieu_pkg.sv
// Types and shared helpers for the interrupt entry unit
`include "ieu_map.svh"

package ieu_pkg;

  typedef enum logic [2:0] {
    IEU_IDLE,
    IEU_PUSH,
    IEU_VEC_HI,
    IEU_VEC_LO,
    IEU_LOAD,
    IEU_DONE
  } ieu_state_e;

  typedef logic [`IEU_NSRC-1:0] ieu_src_t;
  typedef logic [`IEU_IDX_W-1:0] ieu_idx_t;

  // Lowest set bit wins: source 0 is the most urgent hardware request
  function automatic ieu_idx_t ieu_first_idx(input ieu_src_t v);
    ieu_idx_t r;
    r = '0;
    for (int i = `IEU_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[`IEU_IDX_W-1:0];
      end
    end
    return r;
  endfunction

  // Each hardware source owns a two-byte vector below the software trap vector
  function automatic logic [15:0] ieu_hw_vec(input ieu_idx_t idx);
    return `IEU_VEC_HW_BASE - {12'h000, idx, 1'b0};
  endfunction

endpackage

// ### hdl/ieu_prio.sv
// Priority picker: qualifies requests and chooses the vector to enter
`timescale 1ns/1ns
`default_nettype none

module ieu_prio
  import ieu_pkg::*;
(
  ieu_sel_if.pick sel
);
  ieu_src_t qual;

  // Software trap ignores the mask and outranks every hardware source
  always_comb begin
    qual = sel.req & sel.en & {`IEU_NSRC{~sel.imask}};
    sel.is_trap = sel.trap;
    sel.take = sel.trap | (|qual);
    if (sel.trap) begin
      sel.vec = `IEU_VEC_TRAP;
    end else begin
      sel.vec = ieu_hw_vec(ieu_first_idx(qual));
    end
  end
endmodule

`default_nettype wire

// ### hdl/ieu_sel_if.sv
// Selection bundle between the entry sequencer and the priority picker
`timescale 1ns/1ns
`default_nettype none

interface ieu_sel_if
  import ieu_pkg::*;
();
  ieu_src_t req;
  ieu_src_t en;
  logic imask;
  logic trap;
  logic take;
  logic is_trap;
  logic [15:0] vec;

  modport pick (input req, input en, input imask, input trap, output take, output is_trap, output vec);
  modport seq (output req, output en, output imask, output trap, input take, input is_trap, input vec);
endinterface

`default_nettype wire

// ### hdl/ieu_top.sv
// Interrupt entry unit: boundary check, arbitration, stacking and vector fetch
//
// Summary of operation
// - Current instruction always completes before entry.
// - Evaluate pending requests at each instruction boundary.
// - Enter only if mask clear and source enabled.
// - Otherwise allow the next instruction fetch.
// - Highest priority qualifying request is serviced first.
// - Request pending at handler return enters immediately.
// - High index register is never stacked.
// - Software trap ignores mask, priority 0, vector FFFC.
// - Software trap stacks counter, hardware stacks counter-1.
// - Status flags show which maskable sources request; only enabled sources are flagged.
`timescale 1ns/1ns
`default_nettype none

module ieu_top
  import ieu_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic INSTR_DONE,
  input wire logic TRAP_EXEC,
  input wire logic [7:0] IRQ_REQ,
  input wire logic [7:0] IRQ_EN,
  input wire logic [7:0] COND_FLAGS,
  input wire logic [7:0] REG_A,
  input wire logic [7:0] REG_X,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] SP_IN,
  input wire logic [7:0] BUS_RDATA,
  output logic FETCH_OK,
  output logic BUSY,
  output logic [15:0] BUS_ADDR,
  output logic [7:0] BUS_WDATA,
  output logic BUS_WE,
  output logic BUS_RE,
  output logic PC_LOAD,
  output logic [15:0] PC_NEW,
  output logic [15:0] SP_NEW,
  output logic SET_IMASK,
  output logic [7:0] INT_FLAGS
);

  ieu_sel_if sel ();

  ieu_state_e state;
  ieu_state_e next_state;
  logic [2:0] step;
  logic [2:0] next_step;
  logic [15:0] sp_base;
  logic [15:0] next_sp_base;
  logic [15:0] stk_pc;
  logic [15:0] next_stk_pc;
  logic [7:0] stk_a;
  logic [7:0] next_stk_a;
  logic [7:0] stk_x;
  logic [7:0] next_stk_x;
  logic [7:0] stk_cond;
  logic [7:0] next_stk_cond;
  logic [15:0] vec_addr;
  logic [15:0] next_vec_addr;
  logic [7:0] vec_hi;
  logic [7:0] next_vec_hi;
  logic [15:0] bus_addr;
  logic [15:0] next_bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] next_bus_wdata;
  logic bus_we;
  logic next_bus_we;
  logic bus_re;
  logic next_bus_re;
  logic pc_load;
  logic next_pc_load;
  logic [15:0] pc_new;
  logic [15:0] next_pc_new;
  logic [15:0] sp_new;
  logic [15:0] next_sp_new;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic start;

  // Requests come from logic on this clock, so no synchronisers are needed
  assign sel.req = IRQ_REQ;
  assign sel.en = IRQ_EN;
  assign sel.imask = COND_FLAGS[`IEU_IMASK_BIT];
  assign sel.trap = TRAP_EXEC;

  ieu_prio u_prio (
    .sel(sel)
  );

  // Decision is only made at an instruction boundary while idle
  assign start = INSTR_DONE && (state == IEU_IDLE) && sel.take;

  // Fetch may go on while idle unless the boundary just turned into an entry
  assign FETCH_OK = (state == IEU_IDLE) && !start;
  assign BUSY = (state != IEU_IDLE);

  // Stack byte for a given push step; no slot exists for the high index
  function automatic logic [7:0] push_byte(input logic [2:0] s, input logic [15:0] pc,
                                           input logic [7:0] x, input logic [7:0] a,
                                           input logic [7:0] c);
    logic [7:0] r;
    r = c;
    unique case (s)
      3'h0: r = pc[7:0];
      3'h1: r = pc[15:8];
      3'h2: r = x;
      3'h3: r = a;
      default: r = c;
    endcase
    return r;
  endfunction

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_step = step;
    unique case (state)
      IEU_IDLE: begin
        if (start) begin
          next_state = IEU_PUSH;
          next_step = 3'h0;
        end
      end
      IEU_PUSH: begin
        if (step == `IEU_PUSH_LAST) begin
          next_state = IEU_VEC_HI;
        end else begin
          next_step = step + 3'h1;
        end
      end
      IEU_VEC_HI: next_state = IEU_VEC_LO;
      IEU_VEC_LO: next_state = IEU_LOAD;
      IEU_LOAD: next_state = IEU_DONE;
      IEU_DONE: next_state = IEU_IDLE;
    endcase
  end

  // Context captured at the boundary so the CPU may move on meanwhile
  always_comb begin
    next_sp_base = sp_base;
    next_stk_pc = stk_pc;
    next_stk_a = stk_a;
    next_stk_x = stk_x;
    next_stk_cond = stk_cond;
    next_vec_addr = vec_addr;
    next_vec_hi = vec_hi;
    next_pc_new = pc_new;
    next_sp_new = sp_new;
    if (start) begin
      next_sp_base = SP_IN;
      next_stk_pc = sel.is_trap ? PC_IN : PC_IN - 16'h0001;
      next_stk_a = REG_A;
      next_stk_x = REG_X;
      next_stk_cond = COND_FLAGS;
      next_vec_addr = sel.vec;
    end
    // Read data lags the address by one cycle
    if (state == IEU_VEC_LO) begin
      next_vec_hi = BUS_RDATA;
    end
    if (state == IEU_LOAD) begin
      next_pc_new = {vec_hi, BUS_RDATA};
      next_sp_new = sp_base - `IEU_PUSH_COUNT;
    end
  end

  // Registered bus strobes derived from where the sequencer goes next
  always_comb begin
    next_bus_addr = 16'h0000;
    next_bus_wdata = 8'h00;
    next_bus_we = 1'b0;
    next_bus_re = 1'b0;
    next_pc_load = 1'b0;
    if (next_state == IEU_PUSH) begin
      next_bus_we = 1'b1;
      next_bus_addr = next_sp_base - {13'h0000, next_step};
      next_bus_wdata = push_byte(next_step, next_stk_pc, next_stk_x, next_stk_a, next_stk_cond);
    end else if (next_state == IEU_VEC_HI) begin
      next_bus_re = 1'b1;
      next_bus_addr = vec_addr;
    end else if (next_state == IEU_VEC_LO) begin
      next_bus_re = 1'b1;
      next_bus_addr = vec_addr + 16'h0001;
    end else if (next_state == IEU_DONE) begin
      next_pc_load = 1'b1;
    end
  end

  // Status shows enabled maskable sources that request, regardless of mask
  always_comb begin
    next_flags = IRQ_REQ & IRQ_EN;
  end

  // State registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= IEU_IDLE;
      step <= 3'h0;
      sp_base <= 16'h0000;
      stk_pc <= 16'h0000;
      stk_a <= 8'h00;
      stk_x <= 8'h00;
      stk_cond <= 8'h00;
      vec_addr <= 16'h0000;
      vec_hi <= 8'h00;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
      bus_we <= 1'b0;
      bus_re <= 1'b0;
      pc_load <= 1'b0;
      pc_new <= 16'h0000;
      sp_new <= 16'h0000;
      flags <= 8'h00;
    end else begin
      state <= next_state;
      step <= next_step;
      sp_base <= next_sp_base;
      stk_pc <= next_stk_pc;
      stk_a <= next_stk_a;
      stk_x <= next_stk_x;
      stk_cond <= next_stk_cond;
      vec_addr <= next_vec_addr;
      vec_hi <= next_vec_hi;
      bus_addr <= next_bus_addr;
      bus_wdata <= next_bus_wdata;
      bus_we <= next_bus_we;
      bus_re <= next_bus_re;
      pc_load <= next_pc_load;
      pc_new <= next_pc_new;
      sp_new <= next_sp_new;
      flags <= next_flags;
    end
  end

  // Mask is set together with the counter load so the handler starts masked
  assign BUS_ADDR = bus_addr;
  assign BUS_WDATA = bus_wdata;
  assign BUS_WE = bus_we;
  assign BUS_RE = bus_re;
  assign PC_LOAD = pc_load;
  assign SET_IMASK = pc_load;
  assign PC_NEW = pc_new;
  assign SP_NEW = sp_new;
  assign INT_FLAGS = flags;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  logic [7:0] qual_chk;
  assign qual_chk = IRQ_REQ & IRQ_EN;

  sequence push_five;
    (bus_we && !bus_re) [*5];
  endsequence

  sequence vec_fetch(logic [15:0] v);
    (bus_re && bus_addr == v) ##1 (bus_re && bus_addr == v + 16'h0001);
  endsequence

  sequence load_done;
    !bus_re ##1 (pc_load && SET_IMASK);
  endsequence

  entry_after_done_a: assert property ($rose(BUSY) |-> $past(INSTR_DONE))
    else $error("Entry began without an instruction boundary");

  // Decision is checked against the qualifier rebuilt from the pins, not the picker's own output
  boundary_decides_a: assert property ((INSTR_DONE && !BUSY) |->
    (FETCH_OK == !(TRAP_EXEC || (qual_chk != 8'h00 && !COND_FLAGS[`IEU_IMASK_BIT]))))
    else $error("Boundary neither fetched nor entered");

  mask_blocks_a: assert property ((INSTR_DONE && !BUSY && !TRAP_EXEC && COND_FLAGS[`IEU_IMASK_BIT])
                                  |-> FETCH_OK ##1 !BUSY)
    else $error("Masked request was entered");

  none_fetches_a: assert property ((INSTR_DONE && !BUSY && !TRAP_EXEC && qual_chk == 8'h00)
                                   |-> FETCH_OK ##1 !BUSY)
    else $error("Fetch blocked with nothing pending");

  prio_pick_a: assert property ((start && !TRAP_EXEC) |=>
    vec_addr == ieu_hw_vec(ieu_first_idx($past(qual_chk))))
    else $error("Wrong source chosen");

  trap_nomask_a: assert property ((INSTR_DONE && !BUSY && TRAP_EXEC) |->
    !FETCH_OK ##1 (vec_addr == `IEU_VEC_TRAP))
    else $error("Software trap not entered at its vector");

  reentry_ok_a: assert property ((pc_load && qual_chk != 8'h00) |=> !BUSY)
    else $error("Unit not idle after entry to evaluate next request");

  // A request still pending at the handler's return boundary must enter before the next fetch
  pending_enters_a: assert property ((INSTR_DONE && !BUSY && !COND_FLAGS[`IEU_IMASK_BIT] && qual_chk != 8'h00)
                                     |-> !FETCH_OK ##1 BUSY)
    else $error("Pending request not entered at boundary");

  entry_seq_a: assert property (start |=> push_five ##1 vec_fetch(vec_addr) ##1 load_done)
    else $error("Entry sequence has wrong shape");

  pc_stack_a: assert property (start |=> bus_wdata == ($past(TRAP_EXEC) ? $past(PC_IN[7:0])
                                                      : $past(PC_IN[7:0]) - 8'h01))
    else $error("Stacked counter low byte wrong");

  flags_show_a: assert property (##1 INT_FLAGS == $past(qual_chk))
    else $error("Status flags do not follow requests");

endmodule

`default_nettype wire

// ### verif/ieu_mem_model.sv
// Far-side memory model: answers the vector fetches of the entry unit
`timescale 1ns/1ns
`default_nettype none

module ieu_mem_model
  import ieu_pkg::*;
(
  input wire logic CLK,
  input wire logic BUS_RE,
  input wire logic [15:0] BUS_ADDR,
  output var logic [7:0] BUS_RDATA
);
  initial BUS_RDATA = 8'h00;

  // Read data lands one cycle after the strobe
  // Between reads the byte flips each cycle, so a late capture shows up as a wrong vector
  always @(posedge CLK) begin
    if (BUS_RE) begin
      BUS_RDATA <= BUS_ADDR[7:0] ^ 8'h3C;
    end else begin
      BUS_RDATA <= ~BUS_RDATA;
    end
  end
endmodule

`default_nettype wire

// ### verif/interrupt_entry_arbitration_bench.sv
// Self-checking bench for the interrupt entry unit
`timescale 1ns/1ns
`default_nettype none

module interrupt_entry_arbitration_bench
  import ieu_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_done = 1'b0;
  logic trap_exec = 1'b0;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic [7:0] cond = 8'h00;
  logic [7:0] reg_a = 8'h11;
  logic [7:0] reg_x = 8'h22;
  logic [15:0] pc = 16'h1234;
  logic [15:0] sp = 16'h00ff;
  logic [7:0] rdata;
  logic fetch_ok, busy, bus_we, bus_re, pc_load, set_imask;
  logic [15:0] bus_addr, pc_new, sp_new;
  logic [7:0] wdata, flags;
  int n_mismatch = 0;
  int checked = 0;

  // Free-running system clock
  always #5 clk = ~clk;

  ieu_top DUT (
    .CLK(clk), .ARST_N(arst_n), .INSTR_DONE(instr_done), .TRAP_EXEC(trap_exec),
    .IRQ_REQ(irq_req), .IRQ_EN(irq_en), .COND_FLAGS(cond), .REG_A(reg_a), .REG_X(reg_x),
    .PC_IN(pc), .SP_IN(sp), .BUS_RDATA(rdata), .FETCH_OK(fetch_ok), .BUSY(busy),
    .BUS_ADDR(bus_addr), .BUS_WDATA(wdata), .BUS_WE(bus_we), .BUS_RE(bus_re),
    .PC_LOAD(pc_load), .PC_NEW(pc_new), .SP_NEW(sp_new), .SET_IMASK(set_imask),
    .INT_FLAGS(flags)
  );

  ieu_mem_model mem (
    .CLK(clk), .BUS_RE(bus_re), .BUS_ADDR(bus_addr), .BUS_RDATA(rdata)
  );

  // Compare one observed value with its expectation
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Byte the memory model returns for a vector address
  function automatic logic [7:0] vb(input logic [15:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction

  // Boundaries that must not enter: masked, disabled, and no boundary at all
  task no_entry;
    @(negedge clk);
    cond = 8'h08;
    irq_req = 8'h81;
    irq_en = 8'h01;
    instr_done = 1'b1;
    #1 chk(fetch_ok, 1);
    @(negedge clk);
    chk(flags, 8'h01);
    cond = 8'h00;
    irq_en = 8'h00;
    #1 chk(fetch_ok, 1);
    @(negedge clk);
    chk(busy, 0);
    instr_done = 1'b0;
    irq_en = 8'h01;
    #1 chk(fetch_ok, 1);
    @(negedge clk);
    chk(busy, 0);
    irq_en = 8'h00;
  endtask

  // One full entry: decision, five stack writes, vector fetch, counter load
  task entry(input logic sw, input logic [7:0] rq, input logic [15:0] vec, input logic [15:0] spc);
    logic [7:0] stk [5];
    @(negedge clk);
    stk = '{spc[7:0], spc[15:8], reg_x, reg_a, cond};
    trap_exec = sw;
    irq_req = rq;
    irq_en = 8'hff;
    instr_done = 1'b1;
    #1 chk(fetch_ok, 0);
    @(negedge clk);
    instr_done = 1'b0;
    trap_exec = 1'b0;
    chk(flags, rq);
    for (int i = 0; i < 5; i++) begin
      chk({busy, bus_we, bus_re, bus_addr, wdata}, {3'b110, sp - 16'(i), stk[i]});
      // A boundary during entry is ignored
      if (i == 2) begin
        instr_done = 1'b1;
        #1 chk(fetch_ok, 0);
      end
      @(negedge clk);
      instr_done = 1'b0;
    end
    chk({bus_we, bus_re, bus_addr}, {2'b01, vec});
    @(negedge clk);
    chk({bus_we, bus_re, bus_addr}, {2'b01, vec + 16'h0001});
    @(negedge clk);
    chk({bus_we, bus_re, pc_load}, 3'b000);
    @(negedge clk);
    chk({pc_load, set_imask, busy, pc_new, sp_new}, {3'b111, vb(vec), vb(vec + 16'h0001), sp - 16'h0005});
    @(negedge clk);
    chk({busy, pc_load, set_imask}, 3'b000);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    no_entry();
    entry(1'b0, 8'h0c, 16'hfff6, pc - 16'h0001);
    // Request still pending when the handler returns
    entry(1'b0, 8'h0c, 16'hfff6, pc - 16'h0001);
    entry(1'b0, 8'h81, 16'hfffa, pc - 16'h0001);
    cond = 8'h08;
    entry(1'b1, 8'h01, 16'hfffc, pc);
    cond = 8'h00;
    entry(1'b1, 8'h01, 16'hfffc, pc);
    irq_req = 8'h00;
    repeat (2) @(negedge clk);
    end_sim();
  end

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule

`default_nettype wire
